// ===== src/tef_pkg.sv
// Package for the timer event flag and software event generation block.
// Assumes a 32-bit register port with one-cycle read latency.
package tef_pkg;
  localparam int NCH = 4;
  localparam int AW  = 8;
  localparam int CW  = 16;

  // Register offsets
  localparam logic [AW-1:0] ADDR_IER = 8'h0C;
  localparam logic [AW-1:0] ADDR_SR  = 8'h10;
  localparam logic [AW-1:0] ADDR_EGR = 8'h14;
  localparam logic [AW-1:0] ADDR_CFG = 8'h20;

  // Field positions, status register
  localparam int SR_UPD  = 0;
  localparam int SR_CC   = 1;
  localparam int SR_COM  = 5;
  localparam int SR_TRG  = 6;
  localparam int SR_BRK  = 7;
  localparam int SR_OVC  = 9;
  localparam int SR_W    = 13;
  // Field positions, event generation register
  localparam int EG_UPD  = 0;
  localparam int EG_CC   = 1;
  localparam int EG_COM  = 5;
  localparam int EG_TRG  = 6;
  localparam int EG_BRK  = 7;
  localparam int EG_W    = 8;
  // Config register: channel input mode bits 3:0, output enable at bit 8
  localparam int CFG_IN   = 0;
  localparam int CFG_MOE  = 8;

  localparam logic [SR_W-1:0] SR_RESET  = 13'h0000;
  localparam logic [SR_W-1:0] IER_RESET = 13'h0000;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [31:0]   wdata;
    logic          wr;
    logic          rd;
  } tef_req_s;

  typedef struct packed {
    logic           upd;
    logic [NCH-1:0] cc;
    logic           com;
    logic           trg;
    logic           brk;
  } tef_evt_s;
endpackage : tef_pkg

// ===== src/tef_flag.sv
// One sticky status flag: hardware set, software clear by writing zero.
// Assumes the write strobe is a single cycle.
`timescale 1ns/1ps
module tef_flag (
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  // Control
  input  wire logic i_set,
  input  wire logic i_clr,
  // State
  output logic      o_flag
);
  typedef struct packed { logic f; } tef_flag_st_s;
  tef_flag_st_s st_q, st_d;

  always_comb begin
    st_d = st_q;
    if (i_clr) st_d.f = 1'b0;
    if (i_set) st_d.f = 1'b1; // Set beats clear
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) st_q <= '0;
    else st_q <= st_d;
  end

  assign o_flag = st_q.f;

  set_wins_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_set |=> o_flag) else $error("flag lost its set");
  clr_works_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_clr && !i_set) |=> !o_flag) else $error("flag not cleared");
endmodule // tef_flag

// ===== src/tef_capture.sv
// Capture register of one channel, loaded from the counter.
// Assumes the counter is on the same clock.
`timescale 1ns/1ps
module tef_capture #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst_n,
  // Capture
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_cnt,
  output logic      [W-1:0] o_val
);
  typedef struct packed { logic [W-1:0] v; } tef_cap_st_s;
  tef_cap_st_s st_q, st_d;

  always_comb begin
    st_d = st_q;
    if (i_load) st_d.v = i_cnt;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) st_q <= '0;
    else st_q <= st_d;
  end

  assign o_val = st_q.v;

  load_value_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_load |=> o_val == $past(i_cnt)) else $error("capture lost count");
endmodule // tef_capture

// ===== src/tef_top.sv
// Timer status flags and software event generation.
// Assumes counter, compare and capture sources sit on the same clock.
// Operation
// - In input mode a channel 1 capture sets the channel 1 event flag.
// - In output mode a channel 1 compare match sets the channel 1 event flag.
// - Flags are set only by hardware or generation events; writing zero clears, writing one keeps.
// - Every update event sets the update flag, which stays until cleared.
// - Break generate clears main output enable, sets the break flag, raises its request if enabled.
// - Trigger generate sets the trigger flag and raises its request if enabled.
// - Commutation generate commits the preloaded channel control bits; zero does nothing.
// - Channel 1 generate sets the channel 1 event flag and raises its request if enabled.
// - A generated capture on an input channel copies the counter to its capture register.
// - A generated capture on an input channel with its event flag already set sets the over-capture flag.
// - Generate bits 2 to 4 act for channels 2 to 4 as bit 1 does for channel 1.
// - Each generation bit is a pulse that returns to zero on its own.
// - A flag raises its interrupt request only while its enable bit is set.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
module tef_top
  import tef_pkg::*;
#(
  parameter int NC = tef_pkg::NCH,
  parameter int CNTW = tef_pkg::CW
) (
  // Clock and reset
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_rst_n,
  // Register port
  input  wire tef_pkg::tef_req_s      i_req,
  output logic [31:0]                 o_rdata,
  // Hardware events from the timer core
  input  wire tef_pkg::tef_evt_s      i_hw_evt,
  input  wire logic [CNTW-1:0]        i_cnt,
  // Generated events to the timer core
  output logic                        o_upd_gen,
  output logic                        o_com_commit,
  output logic                        o_trg_gen,
  output logic                        o_brk_gen,
  output logic [NC-1:0]               o_cc_gen,
  // Outputs
  output logic                        o_main_output_enable,
  output logic [NC*CNTW-1:0]          o_capture,
  output logic                        o_irq
);
  import tef_pkg::*;

  typedef struct packed {
    logic [SR_W-1:0] ier;
    logic [NC-1:0]   ch_in;
    logic            main_output_enable;
    logic [EG_W-1:0] egr;
    logic [31:0]     rdata;
  } tef_st_s;
  tef_st_s st_q, st_d;

  // Decoded write of one register
  function automatic logic wr_hit(input tef_req_s r, input logic [AW-1:0] a);
    return r.wr && (r.addr == a);
  endfunction

  logic [SR_W-1:0] sr_set, sr_clr, sr_q;
  logic [NC-1:0]   cc_set;

  // Generation pulses stand one cycle after the write, then drop
  wire logic [EG_W-1:0] eg = st_q.egr;

  always_comb begin
    st_d = st_q;
    st_d.egr = '0;
    if (wr_hit(i_req, ADDR_EGR)) st_d.egr = i_req.wdata[EG_W-1:0];
    if (wr_hit(i_req, ADDR_IER)) st_d.ier = i_req.wdata[SR_W-1:0];
    if (wr_hit(i_req, ADDR_CFG)) begin
      st_d.ch_in = i_req.wdata[CFG_IN +: NC];
      st_d.main_output_enable   = i_req.wdata[CFG_MOE];
    end
    if (eg[EG_BRK]) st_d.main_output_enable = 1'b0;
    st_d.rdata = '0;
    if (i_req.rd) begin
      case (i_req.addr)
        ADDR_IER: st_d.rdata = {{(32-SR_W){1'b0}}, st_q.ier};
        ADDR_SR:  st_d.rdata = {{(32-SR_W){1'b0}}, sr_q};
        ADDR_CFG: begin
          st_d.rdata[CFG_IN +: NC] = st_q.ch_in;
          st_d.rdata[CFG_MOE]      = st_q.main_output_enable;
        end
        default:  st_d.rdata = '0; // Write-only and unmapped read as zero
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Flag set sources
  always_comb begin
    sr_set = '0;
    cc_set = i_hw_evt.cc | eg[EG_CC +: NC];
    sr_set[SR_UPD] = i_hw_evt.upd | eg[EG_UPD];
    sr_set[SR_CC +: NC] = cc_set;
    sr_set[SR_COM] = i_hw_evt.com | eg[EG_COM];
    sr_set[SR_TRG] = i_hw_evt.trg | eg[EG_TRG];
    sr_set[SR_BRK] = i_hw_evt.brk | eg[EG_BRK];
    // Over-capture only for input channels whose flag was already up
    sr_set[SR_OVC +: NC] = cc_set & st_q.ch_in & sr_q[SR_CC +: NC];
  end

  // Zero written clears, one written keeps; reserved bits never set
  assign sr_clr = wr_hit(i_req, ADDR_SR) ? ~i_req.wdata[SR_W-1:0] : '0;

  genvar g;
  generate
    for (g = 0; g < SR_W; g++) begin : g_flag
      if (g == SR_BRK + 1) begin : g_rsv
        assign sr_q[g] = 1'b0;
      end else begin : g_live
        tef_flag u_flag (
          .i_ref_clk (i_ref_clk),
          .i_rst_n   (i_rst_n),
          .i_set     (sr_set[g]),
          .i_clr     (sr_clr[g]),
          .o_flag    (sr_q[g])
        );
      end
    end
    for (g = 0; g < NC; g++) begin : g_cap
      tef_capture #(.W(CNTW)) u_cap (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_load    (eg[EG_CC + g] & st_q.ch_in[g]),
        .i_cnt     (i_cnt),
        .o_val     (o_capture[g*CNTW +: CNTW])
      );
    end
  endgenerate

  assign o_irq = |(sr_q & st_q.ier);
  assign o_upd_gen    = eg[EG_UPD];
  assign o_com_commit = eg[EG_COM];
  assign o_trg_gen    = eg[EG_TRG];
  assign o_brk_gen    = eg[EG_BRK];
  assign o_cc_gen     = eg[EG_CC +: NC];
  assign o_main_output_enable = st_q.main_output_enable;
  assign o_rdata = st_q.rdata;

  // Checks
  egr_pulse_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (|eg) && !wr_hit(i_req, ADDR_EGR) |=> eg == '0) else $error("pulse stuck");
  brk_effect_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    eg[EG_BRK] |=> !o_main_output_enable && sr_q[SR_BRK]) else $error("break failed");
  trg_flag_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    eg[EG_TRG] |=> sr_q[SR_TRG]) else $error("trigger flag missing");
  cc1_gen_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    eg[EG_CC] |=> sr_q[SR_CC]) else $error("ch1 flag missing");
  hw_cc1_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_hw_evt.cc[0] |=> sr_q[SR_CC]) else $error("ch1 capture/compare lost");
  upd_flag_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_hw_evt.upd |=> sr_q[SR_UPD]) else $error("update flag missing");
  ovc_flag_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    eg[EG_CC] && st_q.ch_in[0] && sr_q[SR_CC] |=> sr_q[SR_OVC])
    else $error("overcapture missing");
  write_one_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    wr_hit(i_req, ADDR_SR) && i_req.wdata[SR_UPD] && sr_q[SR_UPD] |=> sr_q[SR_UPD])
    else $error("write one cleared flag");
  irq_gate_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_irq |-> |(sr_q & st_q.ier)) else $error("irq without enable");
  com_once_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    wr_hit(i_req, ADDR_EGR) && !i_req.wdata[EG_COM] |=> !o_com_commit)
    else $error("commit without one");
  brk_cov: cover property (@(posedge i_ref_clk) eg[EG_BRK]);
  ovc_cov: cover property (@(posedge i_ref_clk) sr_set[SR_OVC]);
  race_cov: cover property (@(posedge i_ref_clk) sr_set[SR_UPD] && sr_clr[SR_UPD]);
  com_cov: cover property (@(posedge i_ref_clk) eg[EG_COM]);
  cap_cov: cover property (@(posedge i_ref_clk) eg[EG_CC] && st_q.ch_in[0]);

  // Write data fields sampled by the checks below
  wire logic [EG_W-1:0] chk_eg_wdata  = i_req.wdata[EG_W-1:0];
  wire logic [SR_W-1:0] chk_ier_wdata = i_req.wdata[SR_W-1:0];
  wire logic            chk_moe_wdata = i_req.wdata[CFG_MOE];

  // Reset leaves every output quiet
  rst_state_a: assert property (@(posedge i_ref_clk)
    !i_rst_n |=> eg == '0 && !o_main_output_enable && o_rdata == '0 && sr_q == '0 && !o_irq)
    else $error("state not cleared by reset");

  // Generation register takes exactly what was written
  egr_load_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    wr_hit(i_req, ADDR_EGR) |=> eg == $past(chk_eg_wdata))
    else $error("generation pulse differs from write");

  upd_gen_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    eg[EG_UPD] |=> sr_q[SR_UPD])
    else $error("generated update lost");

  com_flag_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    eg[EG_COM] |=> sr_q[SR_COM])
    else $error("commutation flag missing");

  trg_hw_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_hw_evt.trg |=> sr_q[SR_TRG])
    else $error("hardware trigger lost");

  brk_hw_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_hw_evt.brk |=> sr_q[SR_BRK])
    else $error("hardware break lost");

  // No request without an enabled flag behind it
  irq_low_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (sr_q & st_q.ier) == '0 |-> !o_irq)
    else $error("request without enabled flag");

  moe_keep_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !eg[EG_BRK] && !wr_hit(i_req, ADDR_CFG) |=> $stable(o_main_output_enable))
    else $error("output enable moved by itself");

  // Break beats a same-cycle config write
  moe_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    wr_hit(i_req, ADDR_CFG) && !eg[EG_BRK] |=> o_main_output_enable == $past(chk_moe_wdata))
    else $error("output enable write lost");

  ier_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    wr_hit(i_req, ADDR_IER) |=> st_q.ier == $past(chk_ier_wdata))
    else $error("enable write lost");

  // Read data stands only in the cycle after the strobe
  rdata_idle_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !i_req.rd |=> o_rdata == '0)
    else $error("read data without strobe");

  rdata_sr_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_req.rd && i_req.addr == ADDR_SR |=> o_rdata == {{(32-SR_W){1'b0}}, $past(sr_q)})
    else $error("status read wrong");

  rdata_egr_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_req.rd && i_req.addr == ADDR_EGR |=> o_rdata == '0)
    else $error("generation register readable");

  rdata_cfg_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_req.rd && i_req.addr == ADDR_CFG |=> o_rdata[CFG_MOE] == $past(o_main_output_enable))
    else $error("config read wrong");

  // Per channel event, over-capture and capture checks
  generate
    for (g = 0; g < NC; g++) begin : g_ch_chk
      cc_gen_set_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        eg[EG_CC + g] |=> sr_q[SR_CC + g])
        else $error("generated channel event lost");

      cc_hw_set_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_hw_evt.cc[g] |=> sr_q[SR_CC + g])
        else $error("hardware channel event lost");

      ovc_set_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        eg[EG_CC + g] && st_q.ch_in[g] && sr_q[SR_CC + g] |=> sr_q[SR_OVC + g])
        else $error("channel overcapture missing");

      // Output channels never over-capture
      ovc_out_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !st_q.ch_in[g] && !sr_q[SR_OVC + g] |=> !sr_q[SR_OVC + g])
        else $error("overcapture on output channel");

      cap_load_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        eg[EG_CC + g] && st_q.ch_in[g] |=> o_capture[g*CNTW +: CNTW] == $past(i_cnt))
        else $error("channel capture lost count");

      cap_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !(eg[EG_CC + g] && st_q.ch_in[g]) |=> $stable(o_capture[g*CNTW +: CNTW]))
        else $error("capture changed without event");
    end
  endgenerate

  // Per flag set, clear and request checks; reserved bit skipped
  generate
    for (g = 0; g < SR_W; g++) begin : g_flag_chk
      if (g != SR_BRK + 1) begin : g_live_chk
        flag_clear_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
          wr_hit(i_req, ADDR_SR) && !i_req.wdata[g] && !sr_set[g] |=> !sr_q[g])
          else $error("zero write did not clear");

        flag_keep_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
          sr_q[g] && !(wr_hit(i_req, ADDR_SR) && !i_req.wdata[g]) |=> sr_q[g])
          else $error("flag dropped without clear");

        // A status register write can never set a flag
        flag_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
          !sr_q[g] && !sr_set[g] |=> !sr_q[g])
          else $error("flag set without event");

        irq_bit_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
          sr_q[g] && st_q.ier[g] |-> o_irq)
          else $error("enabled flag gave no request");
      end
    end
  endgenerate
endmodule // tef_top

// ===== dv/tef_top_bench.sv
// Self-checking bench for the timer status flags and event generation block.
// Assumes one clock, synchronous reset and a one-cycle-latency register port.
`timescale 1ns/1ps
module tef_top_bench;
  import tef_pkg::*;
  logic              i_ref_clk = 1'b0;
  logic              i_rst_n = 1'b0;
  tef_req_s          i_req = '0;
  tef_evt_s          i_hw_evt = '0;
  logic [CW-1:0]     i_cnt = '0;
  logic              o_upd_gen, o_com_commit, o_trg_gen, o_brk_gen, o_irq;
  logic [NCH-1:0]    o_cc_gen;
  logic              o_main_output_enable;
  logic [NCH*CW-1:0] o_capture;
  logic [31:0]       o_rdata;
  int                n_fail = 0;
  int                n_tests = 0;
  int                cycles = 0;

  tef_top uut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_req(i_req), .o_rdata(o_rdata),
    .i_hw_evt(i_hw_evt), .i_cnt(i_cnt), .o_upd_gen(o_upd_gen), .o_com_commit(o_com_commit),
    .o_trg_gen(o_trg_gen), .o_brk_gen(o_brk_gen), .o_cc_gen(o_cc_gen),
    .o_main_output_enable(o_main_output_enable), .o_capture(o_capture), .o_irq(o_irq));

  always #2.5 i_ref_clk = ~i_ref_clk;

  // Ceiling well above the hundred or so cycles the sequence needs
  always @(posedge i_ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail = n_fail + 1;
      summarize();
    end
  end

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Returns just after the sampling edge, so write effects have landed
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_ref_clk);
    i_req.wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [AW-1:0] a, output logic [31:0] d);
    @(posedge i_ref_clk);
    i_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge i_ref_clk);
    i_req.rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask

  task automatic hw(input tef_evt_s e);
    @(posedge i_ref_clk);
    i_hw_evt <= e;
    @(posedge i_ref_clk);
    i_hw_evt <= '0;
  endtask

  task automatic t_hw_flags();
    logic [31:0] v;
    hw('{upd: 1'b1, cc: 4'h1, com: 1'b0, trg: 1'b0, brk: 1'b0});
    rd(ADDR_SR, v);
    chk("sr_hw_set", v, 32'h0000_0003);
    wr(ADDR_SR, 32'hFFFF_FFFF);
    rd(ADDR_SR, v);
    chk("sr_write_one", v, 32'h0000_0003);
    wr(ADDR_SR, 32'hFFFF_FFFE);
    rd(ADDR_SR, v);
    chk("sr_clear_upd", v, 32'h0000_0002);
    // Clear write and a fresh event in one cycle
    @(posedge i_ref_clk);
    i_req <= '{addr: ADDR_SR, wdata: 32'h0000_0000, wr: 1'b1, rd: 1'b0};
    i_hw_evt <= '{upd: 1'b0, cc: 4'h1, com: 1'b0, trg: 1'b0, brk: 1'b0};
    @(posedge i_ref_clk);
    i_req.wr <= 1'b0;
    i_hw_evt <= '0;
    rd(ADDR_SR, v);
    chk("sr_set_wins", v, 32'h0000_0002);
    rd(ADDR_EGR, v);
    chk("egr_read", v, 32'h0000_0000);
    rd(8'hFC, v);
    chk("unmapped_read", v, 32'h0000_0000);
  endtask

  task automatic t_gen_all();
    logic [31:0] v;
    wr(ADDR_SR, 32'h0000_0000);
    for (int b = 0; b < EG_W; b++) begin
      wr(ADDR_EGR, 32'h0000_0001 << b);
      chk("gen_pulse", {o_brk_gen, o_trg_gen, o_com_commit, o_cc_gen, o_upd_gen},
          32'h0000_0001 << b);
      @(posedge i_ref_clk);
      #1;
      chk("gen_cleared", {o_brk_gen, o_trg_gen, o_com_commit, o_cc_gen, o_upd_gen},
          32'h0000_0000);
    end
    wr(ADDR_EGR, 32'h0000_0000);
    chk("gen_zero", {o_brk_gen, o_trg_gen, o_com_commit, o_cc_gen, o_upd_gen},
        32'h0000_0000);
    rd(ADDR_SR, v);
    // Commutation flag not judged here
    chk("sr_after_gen", v & 32'hFFFF_FFDF, 32'h0000_00DF);
  endtask

  task automatic t_capture();
    logic [31:0] v;
    wr(ADDR_CFG, 32'h0000_010F);
    wr(ADDR_SR, 32'h0000_0000);
    for (int g = 0; g < NCH; g++) begin
      i_cnt <= CW'(16'h1230 + g);
      wr(ADDR_EGR, 32'h0000_0002 << g);
      @(posedge i_ref_clk);
      #1;
      chk("capture_val", o_capture[g*CW+:CW], 32'h0000_1230 + g);
      wr(ADDR_EGR, 32'h0000_0002 << g);
    end
    rd(ADDR_SR, v);
    chk("sr_overcapture", v, 32'h0000_1E1E);
    chk("moe_set", o_main_output_enable, 1'b1);
    wr(ADDR_EGR, 32'h0000_0080);
    @(posedge i_ref_clk);
    #1;
    chk("moe_break", o_main_output_enable, 1'b0);
  endtask

  task automatic t_irq();
    logic [31:0] v;
    wr(ADDR_SR, 32'h0000_0000);
    wr(ADDR_IER, 32'h0000_0001);
    chk("irq_idle", o_irq, 1'b0);
    hw('{upd: 1'b1, cc: 4'h0, com: 1'b0, trg: 1'b0, brk: 1'b0});
    #1;
    chk("irq_raised", o_irq, 1'b1);
    wr(ADDR_IER, 32'h0000_0002);
    chk("irq_masked", o_irq, 1'b0);
    rd(ADDR_IER, v);
    chk("ier_read", v, 32'h0000_0002);
  endtask

  initial begin
    logic [31:0] v;
    repeat (5) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    rd(ADDR_SR, v);
    chk("sr_reset", v, 32'h0000_0000);
    chk("moe_reset", o_main_output_enable, 1'b0);
    t_hw_flags();
    t_gen_all();
    t_capture();
    t_irq();
    summarize();
  end
endmodule // tef_top_bench
